/* logic/hss_pkg.sv */
package hss_pkg;
  // Terminal function codes
  localparam logic [7:0] FUNC_BIAS      = 8'h32; // 50 decimal
  localparam logic [7:0] FUNC_ORIENT    = 8'h2D; // 45 decimal
  localparam logic [7:0] FUNC_POS_OK    = 8'h17; // 23 decimal
  localparam logic [7:0] FUNC_SPD_POS   = 8'h49; // 73 decimal
  // Mode selector values
  localparam logic [7:0] VF_VECTOR_FB   = 8'h05;
  localparam logic [7:0] PULSE_APR      = 8'h02;
  localparam logic [7:0] PULSE_HAPR     = 8'h03;
  // Geometry and ranges
  localparam int         STOP_DIVS      = 4096;
  localparam logic [11:0] STOP_MAX      = 12'hFFF;
  localparam logic [13:0] RANGE_MAX     = 14'h270F; // 9999 pulses
  localparam logic [9:0]  DELAY_MAX     = 10'h3E7;  // 9.99 s in 10 ms units
  // Timing: delay unit of 10 ms at 40 MHz
  localparam int         CLK_HZ         = 40000000;
  localparam int         DELAY_UNIT_MS  = 10;
  localparam int         UNIT_CYCLES    = CLK_HZ / 1000 * DELAY_UNIT_MS;
  // Reset values
  localparam logic [15:0] SPEED_RST     = 16'h0000;
  localparam logic [31:0] POS_RST       = 32'h0000_0000;
  // Display digits kept
  localparam int         DISP_DIGITS    = 4;
  // Sequencer states
  typedef enum logic [2:0] {
    HSS_IDLE   = 3'b000,
    HSS_ACCEL  = 3'b001,
    HSS_WAIT_Z = 3'b010,
    HSS_POSN   = 3'b011,
    HSS_LOCK   = 3'b100
  } hss_state_t;
  // Zero-return modes
  typedef enum logic [1:0] {
    HSS_ZR_LOW   = 2'b00,
    HSS_ZR_HIGH1 = 2'b01,
    HSS_ZR_HIGH2 = 2'b10
  } hss_zr_t;
endpackage : hss_pkg

/* logic/hss_top.sv */
// Behaviour
// - Bias input adds signed bias to speed in pulse position mode
// - Run with orient: accelerate to search speed
// - Orient while running: switch to search speed
// - First Z after speed reached: position control
// - Target one turn forward, two reverse
// - Deceleration from loop gain, not decel time
// - Complete after in-range for delay
// - Complete held until orient released
// - Servo lock until run released
// - Stop position is 1/4096 of a turn
// - Z pulse defines reference point
// - Terminal codes 45 in, 23 out
// - Absolute mode needs curve 05, pulse 02 or 03
// - Pulse 03 gives quadruple resolution
// - Eight stored targets via terminals
// - Zero-return modes; no home search
// - Teaching captures running position
// - Code 73 input switches speed/position
// - Display shows four top digits
`timescale 1ns/1ps
`default_nettype none
module hss_top #(
  parameter int UNIT_CYC = hss_pkg::UNIT_CYCLES // Cycles per 10 ms
) (
  input  wire logic        mclk,                  // 40 MHz clock
  input  wire logic        rst,                   // Sync reset, high
  input  wire logic        term_in_raw,           // Orient pin, async
  input  wire logic        bias_in_raw,           // Bias pin, async
  input  wire logic        spd_in_raw,            // Speed/position pin, async
  input  wire logic        enc_z_raw,             // Encoder Z pulse, async
  input  wire logic        run_cmd_raw,           // Run command, async
  input  wire logic [7:0]  orient_func_sel,       // Input terminal function
  input  wire logic [7:0]  bias_func_sel,         // Bias terminal function
  input  wire logic [7:0]  spd_func_sel,          // Switch terminal function
  input  wire logic [7:0]  out_func_sel,          // Output terminal function
  input  wire logic [15:0] bias_frequency_amount, // Bias magnitude
  input  wire logic        bias_frequency_sign,   // 1 = negative bias
  input  wire logic [15:0] speed_cmd_in,          // Base speed command
  input  wire logic        pulse_pos_mode,        // Pulse-string position mode
  input  wire logic [15:0] home_search_speed,     // Search speed
  input  wire logic        home_search_direction, // 1 = reverse
  input  wire logic [11:0] home_stop_position,    // Stop division 0..4095
  input  wire logic [15:0] encoder_pulses_per_rev,// Encoder pulses per turn
  input  wire logic [13:0] home_completion_range, // Pulses
  input  wire logic [9:0]  home_completion_delay, // 10 ms units
  input  wire logic [7:0]  position_loop_gain,    // Loop gain
  input  wire logic [31:0] motor_speed_fb,        // Present speed
  input  wire logic [31:0] encoder_position,      // Present position, pulses
  input  wire logic [7:0]  vf_curve_select_motor1,// Curve selector
  input  wire logic [7:0]  control_pulse_select,  // Pulse mode selector
  input  wire logic [2:0]  stage_select,          // Stored target index
  input  wire logic [1:0]  zero_return_mode,      // Zero-return selection
  input  wire logic        teach_strobe,          // Capture current position
  input  wire logic [31:0] display_value,         // Value to show
  output var  logic [15:0] speed_cmd_out,         // Speed command to drive
  output var  logic        position_ctrl_active,  // Position loop engaged
  output var  logic [31:0] position_target,       // Target in pulses
  output var  logic [15:0] decel_rate,            // Position-loop decel step
  output var  logic        positioning_complete_output, // Positioning done
  output var  logic        servo_lock,            // Holding position
  output var  logic        abs_mode,              // Absolute position mode
  output var  logic        hires_mode,            // Quadruple resolution
  output var  logic [31:0] abs_target,            // Selected absolute target
  output var  logic [1:0]  zero_return_active,    // Active zero-return mode
  output var  logic [15:0] display_digits         // Four top digits, hex
);
  // Synchroniser stage one and two for each pin
  logic [4:0] sync1_reg;  // First stage, read only by second stage
  logic [4:0] sync2_reg;  // Safe copies
  logic       z_prev_reg; // Edge detect for Z
  logic       ort_prev_reg;
  logic       orientation_request_input, bias, speed_position_switch_input, zpin, run;

  // Double flop all pin inputs
  always_ff @(posedge mclk) begin
    if (rst) begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
    end else begin
      sync1_reg <= {run_cmd_raw, enc_z_raw, spd_in_raw, bias_in_raw, term_in_raw};
      sync2_reg <= sync1_reg;
    end
  end

  assign orientation_request_input  = sync2_reg[0] && (orient_func_sel == hss_pkg::FUNC_ORIENT);
  assign bias = sync2_reg[1] && (bias_func_sel == hss_pkg::FUNC_BIAS);
  assign speed_position_switch_input  = sync2_reg[2] && (spd_func_sel == hss_pkg::FUNC_SPD_POS);
  assign zpin = sync2_reg[3];
  assign run  = sync2_reg[4];

  // Edge history for Z and orient
  always_ff @(posedge mclk) begin
    if (rst) begin
      z_prev_reg   <= 1'b0;
      ort_prev_reg <= 1'b0;
    end else begin
      z_prev_reg   <= zpin;
      ort_prev_reg <= orientation_request_input;
    end
  end

  logic z_rise;
  assign z_rise = zpin && !z_prev_reg;

  // Mode decode
  logic abs_sel, hires_sel;
  assign abs_sel = (vf_curve_select_motor1 == hss_pkg::VF_VECTOR_FB) &&
                   ((control_pulse_select == hss_pkg::PULSE_APR) ||
                    (control_pulse_select == hss_pkg::PULSE_HAPR));
  assign hires_sel = abs_sel && (control_pulse_select == hss_pkg::PULSE_HAPR);

  // A zero-length delay unit would never let the dwell counter advance
  if (UNIT_CYC < 1) begin : g_unit_check
    $error("UNIT_CYC must be at least one");
  end

  // Sequencer state
  hss_pkg::hss_state_t state_reg, state_next;

  // Completion timing, declared early so the sequencer can see it
  logic [31:0] unit_cnt_reg; // Cycles inside the current delay unit
  logic [9:0]  units_reg;    // Whole delay units spent in range
  logic        in_range;     // Remaining distance inside the window
  logic        done_set;     // Completion fires this cycle

  // Stop offset in pulses: stop * ppr / 4096
  logic [27:0] stop_prod;
  logic [31:0] stop_pulses;
  logic [31:0] turns_pulses;
  assign stop_prod   = 28'(home_stop_position) * 28'(encoder_pulses_per_rev);
  assign stop_pulses = 32'(stop_prod >> 12);
  assign turns_pulses = home_search_direction ? 32'({encoder_pulses_per_rev, 1'b0})
                                              : 32'(encoder_pulses_per_rev);

  // Remaining pulse distance
  logic [31:0] remain;
  logic [31:0] diff;
  assign diff   = position_target - encoder_position;
  assign remain = diff[31] ? (~diff + 32'h1) : diff;

  logic speed_reached;
  assign speed_reached = (motor_speed_fb == 32'(home_search_speed));

  // Sequencer next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      hss_pkg::HSS_IDLE: begin
        if (orientation_request_input && run && !abs_sel) state_next = hss_pkg::HSS_ACCEL;
      end
      hss_pkg::HSS_ACCEL: begin
        if (!orientation_request_input || !run) state_next = hss_pkg::HSS_IDLE;
        else if (speed_reached) state_next = hss_pkg::HSS_WAIT_Z;
      end
      hss_pkg::HSS_WAIT_Z: begin
        if (!orientation_request_input || !run) state_next = hss_pkg::HSS_IDLE;
        else if (z_rise) state_next = hss_pkg::HSS_POSN;
      end
      hss_pkg::HSS_POSN: begin
        if (!run) state_next = hss_pkg::HSS_IDLE;
        // Lock on the same edge that raises completion, not one later
        else if (done_set) state_next = hss_pkg::HSS_LOCK;
      end
      hss_pkg::HSS_LOCK: begin
        if (!run) state_next = hss_pkg::HSS_IDLE;
      end
      default: state_next = hss_pkg::HSS_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge mclk) begin
    if (rst) state_reg <= hss_pkg::HSS_IDLE;
    else     state_reg <= state_next;
  end

  // Target latch at the Z pulse
  always_ff @(posedge mclk) begin
    if (rst) begin
      position_target <= hss_pkg::POS_RST;
    end else if (state_reg == hss_pkg::HSS_WAIT_Z && z_rise) begin
      if (home_search_direction)
        position_target <= encoder_position - turns_pulses - stop_pulses;
      else
        position_target <= encoder_position + turns_pulses + stop_pulses;
    end
  end

  // Speed command with bias and search override
  logic [16:0] biased;
  always_comb begin
    biased = {1'b0, speed_cmd_in};
    if (bias && pulse_pos_mode) begin
      if (bias_frequency_sign) biased = {1'b0, speed_cmd_in} - {1'b0, bias_frequency_amount};
      else                     biased = {1'b0, speed_cmd_in} + {1'b0, bias_frequency_amount};
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      speed_cmd_out <= hss_pkg::SPEED_RST;
    end else if (state_next == hss_pkg::HSS_POSN || state_next == hss_pkg::HSS_LOCK) begin
      // Position loop owns the shaft, so the speed command is zero
      speed_cmd_out <= hss_pkg::SPEED_RST;
    end else if (state_next == hss_pkg::HSS_ACCEL || state_next == hss_pkg::HSS_WAIT_Z) begin
      speed_cmd_out <= home_search_speed;
    end else begin
      speed_cmd_out <= biased[15:0];
    end
  end

  // Position-loop deceleration step
  always_ff @(posedge mclk) begin
    if (rst) begin
      decel_rate <= hss_pkg::SPEED_RST;
    end else begin
      decel_rate <= 16'({8'h00, position_loop_gain} * 16'(remain[7:0]) >> 4);
    end
  end

  // Position control and servo lock flags
  always_ff @(posedge mclk) begin
    if (rst) begin
      position_ctrl_active <= 1'b0;
      servo_lock           <= 1'b0;
    end else begin
      position_ctrl_active <= (state_next == hss_pkg::HSS_POSN) ||
                              (state_next == hss_pkg::HSS_LOCK) || (abs_sel && !speed_position_switch_input);
      servo_lock           <= (state_next == hss_pkg::HSS_LOCK);
    end
  end

  // Completion window
  assign in_range = (state_reg == hss_pkg::HSS_POSN) &&
                    (remain <= 32'(home_completion_range));
  assign done_set = orientation_request_input && in_range && (units_reg >= home_completion_delay) &&
                    (out_func_sel == hss_pkg::FUNC_POS_OK);

  always_ff @(posedge mclk) begin
    if (rst || !in_range) begin
      unit_cnt_reg <= 32'h0;
      units_reg    <= 10'h000;
    end else if (units_reg < home_completion_delay) begin
      if (unit_cnt_reg == 32'(UNIT_CYC - 1)) begin
        unit_cnt_reg <= 32'h0;
        units_reg    <= units_reg + 10'h001;
      end else begin
        unit_cnt_reg <= unit_cnt_reg + 32'h1;
      end
    end
  end

  // Completion output
  always_ff @(posedge mclk) begin
    if (rst) begin
      positioning_complete_output <= 1'b0;
    end else if (!orientation_request_input) begin
      positioning_complete_output <= 1'b0;
    end else if (done_set) begin
      positioning_complete_output <= 1'b1;
    end
  end

  // Absolute mode stored targets
  logic [31:0] stage_mem [8];
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) stage_mem[i] <= hss_pkg::POS_RST;
    end else if (teach_strobe && abs_sel) begin
      stage_mem[stage_select] <= hires_sel ? encoder_position : {encoder_position[29:0], 2'b00};
    end
  end

  // Absolute outputs
  always_ff @(posedge mclk) begin
    if (rst) begin
      abs_mode           <= 1'b0;
      hires_mode         <= 1'b0;
      abs_target         <= hss_pkg::POS_RST;
      zero_return_active <= 2'b00;
    end else begin
      abs_mode   <= abs_sel;
      hires_mode <= hires_sel;
      abs_target <= stage_mem[stage_select];
      zero_return_active <= (abs_sel && zero_return_mode != 2'b11) ? zero_return_mode : 2'b00;
    end
  end

  // Display: keep four top hex digits of nonzero span
  logic [15:0] disp_next;
  always_comb begin
    disp_next = display_value[15:0];
    for (int k = 7; k >= 4; k--) begin
      if (display_value[k*4 +: 4] != 4'h0 && disp_next == display_value[15:0])
        disp_next = display_value[(k-3)*4 +: 16];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) display_digits <= 16'h0000;
    else     display_digits <= disp_next;
  end

  // Orient edge reserved for restart bookkeeping
  logic ort_fall;
  assign ort_fall = ort_prev_reg && !orientation_request_input;
endmodule : hss_top
`default_nettype wire

/* test/hss_motor.sv */
`timescale 1ns/1ps
`default_nettype none
module hss_motor #(
  parameter int LAG  = 3, // Cycles before feedback follows
  parameter int ZPER = 40 // Cycles per turn at speed
) (
  input  wire logic        mclk,                 // Clock
  input  wire logic        rst,                  // Reset
  input  wire logic [15:0] speed_cmd_out,        // Speed asked
  input  wire logic        position_ctrl_active, // Loop on
  input  wire logic        servo_lock,           // Holding
  input  wire logic [31:0] position_target,      // Goal
  output var  logic [31:0] motor_speed_fb,       // Measured speed
  output var  logic [31:0] encoder_position,     // Shaft pulses
  output var  logic        enc_z_raw             // Reference pulse
);
  int lag_cnt; // Feedback lag count
  int z_cnt;   // Turn phase
  // Feedback trails the command, so the sequencer must wait for it
  always_ff @(posedge mclk) begin
    if (rst || lag_cnt == LAG) begin
      motor_speed_fb <= rst ? 32'h0 : {16'h0000, speed_cmd_out};
      lag_cnt <= 0;
    end else begin
      lag_cnt <= lag_cnt + 1;
    end
  end
  // Shaft moves one pulse a cycle only under the position loop
  always_ff @(posedge mclk) begin
    if (rst) begin
      encoder_position <= 32'h0000_1000;
    end else if ((position_ctrl_active || servo_lock) && encoder_position != position_target) begin
      encoder_position <= encoder_position < position_target ? encoder_position + 1 : encoder_position - 1;
    end
  end
  // Z pulse once a turn while turning, still when stopped
  always_ff @(posedge mclk) begin
    z_cnt <= (rst || motor_speed_fb == 0 || z_cnt == ZPER - 1) ? 0 : z_cnt + 1;
    enc_z_raw <= !rst && motor_speed_fb != 0 && z_cnt >= ZPER - 2;
  end
endmodule : hss_motor
`default_nettype wire

/* test/hss_top_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module hss_top_checker (
  input wire logic        mclk,                        // Clock
  input wire logic        rst,                         // Reset
  input wire logic        term_in_raw,                 // Orient pin
  input wire logic        run_cmd_raw,                 // Run pin
  input wire logic [7:0]  vf_curve_select_motor1,      // Curve code
  input wire logic [7:0]  control_pulse_select,        // Pulse code
  input wire logic [15:0] speed_cmd_out,               // Speed out
  input wire logic        position_ctrl_active,        // Loop on
  input wire logic [31:0] position_target,             // Target
  input wire logic        positioning_complete_output, // Done flag
  input wire logic        servo_lock,                  // Holding
  input wire logic        abs_mode,                    // Absolute
  input wire logic        hires_mode                   // Quad res
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_abs_mode_on: assert property (!$past(rst) && $past(vf_curve_select_motor1) == hss_pkg::VF_VECTOR_FB
    && $past(control_pulse_select) == hss_pkg::PULSE_APR |-> abs_mode) else $error("absolute mode missing");
  a_hires_on: assert property (!$past(rst) && $past(vf_curve_select_motor1) == hss_pkg::VF_VECTOR_FB
    && $past(control_pulse_select) == hss_pkg::PULSE_HAPR |-> hires_mode) else $error("hires mode missing");
  a_done_hold: assert property (positioning_complete_output && term_in_raw |=>
    positioning_complete_output) else $error("done dropped early");
  a_done_clear: assert property (!term_in_raw [*4] |=> !positioning_complete_output)
    else $error("done not cleared");
  a_lock_release: assert property (!run_cmd_raw [*4] |=> !servo_lock)
    else $error("lock kept without run");
  a_lock_on_done: assert property ($rose(positioning_complete_output) |-> servo_lock)
    else $error("no lock at done");
  a_pos_speed_zero: assert property (position_ctrl_active && !abs_mode |-> speed_cmd_out == 16'h0000)
    else $error("speed command in position control");
  a_target_stable: assert property (position_ctrl_active && $past(position_ctrl_active) && !abs_mode
    |-> $stable(position_target)) else $error("target moved");
  a_done_cause: assert property ($rose(positioning_complete_output) |-> $past(position_ctrl_active))
    else $error("done without positioning");
  c_search: cover property ($rose(position_ctrl_active));
  c_done: cover property ($rose(positioning_complete_output));
  c_abs: cover property ($rose(abs_mode));
  c_lock: cover property ($fell(servo_lock));
endmodule : hss_top_checker
`default_nettype wire

/* test/hss_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module hss_top_tb;
  localparam int UC = 4; // Short delay unit
  logic mclk, rst, term_in_raw, bias_in_raw, spd_in_raw, run_cmd_raw, teach_strobe, enc_z_raw; // Pins
  logic bias_frequency_sign, pulse_pos_mode, home_search_direction; // Mode bits
  logic [7:0] orient_func_sel, bias_func_sel, spd_func_sel, out_func_sel, position_loop_gain; // Selectors
  logic [7:0] vf_curve_select_motor1, control_pulse_select; // Mode codes
  logic [15:0] bias_frequency_amount, speed_cmd_in, home_search_speed, encoder_pulses_per_rev; // Speeds
  logic [15:0] speed_cmd_out, decel_rate, display_digits; // Outputs
  logic [11:0] home_stop_position; // Stop index
  logic [13:0] home_completion_range; // Window
  logic [9:0] home_completion_delay; // Delay units
  logic [2:0] stage_select; // Stage
  logic [1:0] zero_return_mode, zero_return_active; // Zero return
  logic [31:0] display_value, motor_speed_fb, encoder_position, position_target, abs_target; // Words
  logic position_ctrl_active, positioning_complete_output, servo_lock, abs_mode, hires_mode; // Flags
  int mismatches, checked, seed;
  hss_top #(.UNIT_CYC(UC)) i_dut (.*);
  hss_motor i_motor (.*);
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic step();
    @(posedge mclk);
    #1;
  endtask : step
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  function automatic logic cond(input int s);
    case (s)
      0: return speed_cmd_out === home_search_speed;
      1: return position_ctrl_active === 1'b1;
      2: return positioning_complete_output === 1'b1;
      3: return positioning_complete_output === 1'b0;
      default: return servo_lock === 1'b0;
    endcase
  endfunction : cond
  // Bounded wait; running out is a failure
  task automatic wait_for(input int s, input int lim);
    int n;
    n = 0;
    while (!cond(s) && n < lim) begin
      step();
      n++;
    end
    if (n >= lim) begin
      mismatches++;
      $display("MISMATCH %0t wait %0d", $time, s);
      end_sim();
    end
  endtask : wait_for
  // Reference speed: bias only with pin, code and pulse mode
  function automatic logic [15:0] exp_speed();
    if (bias_in_raw && bias_func_sel == hss_pkg::FUNC_BIAS && pulse_pos_mode)
      return bias_frequency_sign ? speed_cmd_in - bias_frequency_amount : speed_cmd_in + bias_frequency_amount;
    return speed_cmd_in;
  endfunction : exp_speed
  // Reference target: one turn forward, two reverse, plus stop slice
  function automatic logic [31:0] exp_target(input longint pos);
    longint off;
    off = (home_search_direction ? 2 : 1) * encoder_pulses_per_rev
        + home_stop_position * encoder_pulses_per_rev / hss_pkg::STOP_DIVS;
    return 32'(home_search_direction ? pos - off : pos + off);
  endfunction : exp_target
  task automatic home_run(input logic dir, input logic run_first);
    logic [31:0] pos0;
    int inr;
    home_search_direction = dir;
    home_stop_position = 12'($random(seed));
    run_cmd_raw = 1'b1;
    if (run_first) begin
      repeat (6) step();
      chk(speed_cmd_out, exp_speed());
    end
    term_in_raw = 1'b1;
    wait_for(0, 20);
    chk(speed_cmd_out, home_search_speed);
    pos0 = encoder_position;
    wait_for(1, 400);
    chk(position_target, exp_target(pos0));
    inr = 0;
    while (positioning_complete_output !== 1'b1 && inr < 3000) begin
      step();
      if (position_target - encoder_position <= home_completion_range ||
          encoder_position - position_target <= home_completion_range) inr++;
      else inr = 0;
    end
    chk(inr >= home_completion_delay * UC && inr <= home_completion_delay * UC + 4, 1);
    chk(servo_lock, 1);
    term_in_raw = 1'b0;
    wait_for(3, 10);
    chk(servo_lock, 1);
    run_cmd_raw = 1'b0;
    wait_for(4, 10);
  endtask : home_run
  initial begin
    seed = 29;
    {rst, term_in_raw, bias_in_raw, spd_in_raw, run_cmd_raw, teach_strobe} = 6'b100000;
    {bias_frequency_sign, pulse_pos_mode, home_search_direction} = 3'b000;
    {orient_func_sel, bias_func_sel, spd_func_sel} = {hss_pkg::FUNC_ORIENT, hss_pkg::FUNC_BIAS, 8'h00};
    out_func_sel = hss_pkg::FUNC_POS_OK;
    position_loop_gain = 8'($random(seed));
    {vf_curve_select_motor1, control_pulse_select} = 16'h0000;
    {bias_frequency_amount, speed_cmd_in, home_search_speed} = {16'h0100, 16'h2000, 16'h0300};
    encoder_pulses_per_rev = 16'h0080;
    home_stop_position = 12'h000;
    {home_completion_range, home_completion_delay} = {14'h0002, 10'h003};
    {stage_select, zero_return_mode, display_value} = {3'($random(seed)), 2'h0, 32'($random(seed))};
    repeat (5) @(posedge mclk);
    #1;
    chk(speed_cmd_out, 0);
    rst = 1'b0;
    step();
    chk(speed_cmd_out, exp_speed());
    chk(positioning_complete_output, 0);
    for (int i = 0; i < 8; i++) begin
      bias_func_sel = (i == 6) ? 8'h33 : hss_pkg::FUNC_BIAS;
      pulse_pos_mode = (i != 7);
      bias_in_raw = (i != 5);
      bias_frequency_sign = i[0];
      bias_frequency_amount = 16'($random(seed)) & 16'h0FFF;
      speed_cmd_in = 16'h4000 | (16'($random(seed)) & 16'h3FFF);
      repeat (5) step();
      chk(speed_cmd_out, exp_speed());
    end
    {bias_in_raw, pulse_pos_mode} = 2'b00;
    home_run(1'b0, 1'b0);
    home_run(1'b1, 1'b1);
    for (int i = 0; i < 4; i++) begin
      vf_curve_select_motor1 = (i == 3) ? 8'h00 : hss_pkg::VF_VECTOR_FB;
      control_pulse_select = (i == 0) ? 8'h01 : (i == 2) ? hss_pkg::PULSE_HAPR : hss_pkg::PULSE_APR;
      repeat (3) step();
      if (i != 2) chk(abs_mode, i == 1);
      if (i != 3) chk(hires_mode, i == 2);
    end
    // no search in absolute mode, wrong orient code
    for (int i = 0; i < 2; i++) begin
      vf_curve_select_motor1 = (i == 0) ? hss_pkg::VF_VECTOR_FB : 8'h00;
      orient_func_sel = (i == 0) ? hss_pkg::FUNC_ORIENT : 8'h2C;
      {term_in_raw, run_cmd_raw} = 2'b11;
      repeat (30) step();
      chk(speed_cmd_out === home_search_speed, 0);
      {term_in_raw, run_cmd_raw} = 2'b00;
      repeat (6) step();
    end
    // switch pin releases loop, teach, zero return, display
    {vf_curve_select_motor1, control_pulse_select} = {hss_pkg::VF_VECTOR_FB, hss_pkg::PULSE_APR};
    {spd_func_sel, spd_in_raw, zero_return_mode} = {hss_pkg::FUNC_SPD_POS, 1'b1, 2'h1};
    display_value = 32'h0012_3456;
    repeat (4) step();
    chk(position_ctrl_active, 0);
    chk(zero_return_active, 1);
    chk(display_digits, 16'h1234);
    teach_strobe = 1'b1;
    step();
    teach_strobe = 1'b0;
    step();
    chk(abs_target, {encoder_position[29:0], 2'b00});
    spd_in_raw = 1'b0;
    repeat (4) step();
    chk(position_ctrl_active, 1);
    end_sim();
  end
endmodule : hss_top_tb
bind hss_top hss_top_checker i_chk (.mclk, .rst, .term_in_raw, .run_cmd_raw, .vf_curve_select_motor1,
  .control_pulse_select, .speed_cmd_out, .position_ctrl_active, .position_target,
  .positioning_complete_output, .servo_lock, .abs_mode, .hires_mode);
`default_nettype wire
